//--- hw/uart_line_format_pkg.sv
// package: register map, field layout, reset values and types of the line/format block
package uart_line_format_pkg;

  // register byte offsets on apb
  localparam logic [7:0] rbr_thr_off  = 8'h00;
  localparam logic [7:0] ier_off      = 8'h04;
  localparam logic [7:0] fifo_ctl_off = 8'h08;
  localparam logic [7:0] line_ctl_off = 8'h0c;
  localparam logic [7:0] modem_ctl_off = 8'h10;
  localparam logic [7:0] feat_ctl_off = 8'h20;
  localparam logic [7:0] enh_feat_off = 8'h24;
  localparam logic [7:0] rx_lvl_off   = 8'h28;
  localparam logic [7:0] tx_lvl_off   = 8'h2c;
  localparam logic [7:0] status_off   = 8'h30;
  localparam logic [7:0] fmt_off      = 8'h34;

  // field positions
  localparam int fcr_en_bit      = 0;
  localparam int fcr_tx_trig_lsb = 4;
  localparam int fcr_rx_trig_lsb = 6;
  localparam int feature_control_tbl_lsb    = 6;
  localparam int efr_enh_bit     = 4;
  localparam int efr_autorts_bit = 6;
  localparam int lcr_stop_bit    = 2;
  localparam int lcr_par_en_bit  = 3;
  localparam int lcr_par_ty_bit  = 4;
  localparam int lcr_force_bit   = 5;
  localparam int lcr_break_bit   = 6;
  localparam int lcr_dlab_bit    = 7;
  localparam int mcr_dtr_bit     = 0;
  localparam int mcr_rts_bit     = 1;
  localparam int mcr_flow_bit    = 2;

  // reset values
  localparam logic [7:0] fifo_ctl_rst = 8'h00;
  localparam logic [7:0] line_ctl_rst = 8'h00;
  localparam logic [7:0] modem_ctl_rst = 8'h00;
  localparam logic [7:0] feat_ctl_rst = 8'h00;
  localparam logic [7:0] enh_feat_rst = 8'h00;
  localparam logic [6:0] prog_lvl_rst = 7'h01;
  localparam logic [7:0] divisor_low_rst  = 8'h01;
  localparam logic [7:0] divisor_high_rst = 8'h00;

  // trigger tables as literal levels
  localparam logic [6:0] lvl_1  = 7'h01;
  localparam logic [6:0] lvl_4  = 7'h04;
  localparam logic [6:0] lvl_8  = 7'h08;
  localparam logic [6:0] lvl_14 = 7'h0e;
  localparam logic [6:0] lvl_16 = 7'h10;
  localparam logic [6:0] lvl_24 = 7'h18;
  localparam logic [6:0] lvl_28 = 7'h1c;
  localparam logic [6:0] lvl_30 = 7'h1e;
  localparam logic [6:0] lvl_32 = 7'h20;
  localparam logic [6:0] lvl_56 = 7'h38;
  localparam logic [6:0] lvl_60 = 7'h3c;

  typedef enum logic [1:0] {tbl_a, tbl_b, tbl_c, tbl_d} trig_table_t;

  // character format handed to the shifters
  typedef struct packed {
    logic [3:0] data_bits;   // 5..8
    logic [1:0] stop_halves; // 2,3,4 half bit times
    logic       par_en;
    logic       par_even;
    logic       par_forced;
    logic       par_force_val;
    logic       tx_break;
  } char_format_t;

  // fifo fill levels from the storage
  typedef struct packed {
    logic [6:0] tx_count;
    logic [6:0] rx_count;
  } fifo_levels_t;

  // thresholds and events toward the interrupt logic
  typedef struct packed {
    logic [6:0] tx_thresh;
    logic [6:0] rx_thresh;
    logic       tx_ready_event;
    logic       rx_data_ready_event;
  } trig_events_t;

  typedef struct packed {
    logic [7:0] fifo_ctl;
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] feat_ctl;
    logic [7:0] enh_feat;
    logic [6:0] rx_prog_lvl;
    logic [6:0] tx_prog_lvl;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic       tx_over_thresh;
    logic       tx_fill_seen;
    logic [31:0] prdata;
    logic       pready;
    logic       pslverr;
    logic       data_wr;
    logic [7:0] data_wdata;
    logic       data_rd;
    logic       txd;
    logic       dtr_n;
    logic       rts_n;
    char_format_t fmt;
    trig_events_t trig;
  } state_t;

endpackage : uart_line_format_pkg

//--- hw/uart_line_format_fifo_trigger.sv
// line format, fifo trigger selection and modem output control of one channel
// Operation
// RULE_01: tx threshold from fifo_control tx field, table picked by feature_control
// RULE_02: tx event when count falls below threshold, or on empty if never filled
// RULE_03: tx trigger field writable only when enhanced_feature bit 4 set
// RULE_04: one trigger table serves both directions, last selection wins
// RULE_05: rx threshold from fifo_control upper field within selected table
// RULE_06: tables A, B, C fixed levels; table D programmable both ways
// RULE_07: both trigger fields reset to zero, giving level one each
// RULE_08: line_control bits 1:0 choose 5, 6, 7 or 8 data bits
// RULE_09: stop select gives one, one and a half (5 bits) or two stops
// RULE_10: parity enable adds parity on transmit and checks on receive
// RULE_11: parity type zero odd, one even, same for both directions
// RULE_12: forced parity is one for type zero and zero for type one
// RULE_13: break bit holds transmit output low until software clears it
// RULE_14: line_control top bit steers accesses to divisor latches
// RULE_15: modem_control bit 0 drives active-low terminal-ready pin
// RULE_16: modem_control bit 1 drives active-low request-to-send pin
// RULE_17: terminal-ready goes to auto flow when enabled and flow select one
// RULE_18: request-to-send goes to auto flow when enabled and flow select zero
// RULE_19: fifo_control writes ignored unless fifo enable bit written one
// RULE_20: rx data ready event when rx level reaches rx threshold
// RULE_21: flow select zero uses rts/cts pair, one uses dtr/dsr pair
// RULE_22: programmable table takes levels from separate 7-bit level registers
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
module uart_line_format_fifo_trigger
  import uart_line_format_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // data register path toward fifos
  output logic              data_wr,
  output logic [7:0]        data_wdata,
  output logic              data_rd,
  input  wire logic [7:0]   data_rdata,
  // fifo levels and flow requests
  input  wire fifo_levels_t levels,
  input  wire logic         tx_serial,
  input  wire logic         auto_rts_assert,
  input  wire logic         auto_dtr_assert,
  // format and trigger results
  output char_format_t      fmt,
  output trig_events_t      trig,
  output logic [15:0]       divisor,
  // serial and modem pins
  output logic              txd,
  output logic              dtr_n,
  output logic              rts_n
);

  ////////////////////////////////////////////////////////////////////////////
  // level lookups

  function automatic logic [6:0] rx_level(input trig_table_t t, input logic [1:0] s,
                                          input logic [6:0] prog);
    logic [6:0] r;
    r = lvl_1;
    case (t)
      tbl_a: begin
        case (s)
          2'h0: r = lvl_1;
          2'h1: r = lvl_4;
          2'h2: r = lvl_8;
          default: r = lvl_14;
        endcase
      end
      tbl_b: begin
        case (s)
          2'h0: r = lvl_8;
          2'h1: r = lvl_16;
          2'h2: r = lvl_24;
          default: r = lvl_28;
        endcase
      end
      tbl_c: begin
        case (s)
          2'h0: r = lvl_8;
          2'h1: r = lvl_16;
          2'h2: r = lvl_56;
          default: r = lvl_60;
        endcase
      end
      default: r = prog; // [RULE_22]
    endcase
    return r;
  endfunction : rx_level

  function automatic logic [6:0] tx_level(input trig_table_t t, input logic [1:0] s,
                                          input logic [6:0] prog);
    logic [6:0] r;
    r = lvl_1;
    case (t)
      tbl_a: r = lvl_1;
      tbl_b: begin
        case (s)
          2'h0: r = lvl_16;
          2'h1: r = lvl_8;
          2'h2: r = lvl_24;
          default: r = lvl_30;
        endcase
      end
      tbl_c: begin
        case (s)
          2'h0: r = lvl_8;
          2'h1: r = lvl_16;
          2'h2: r = lvl_32;
          default: r = lvl_56;
        endcase
      end
      default: r = prog; // [RULE_22]
    endcase
    return r;
  endfunction : tx_level

  ////////////////////////////////////////////////////////////////////////////
  // state

  state_t      state_reg;
  state_t      state_next;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  wb;
  logic        dlab;
  trig_table_t tbl;
  logic [1:0]  wlen;
  logic [6:0]  tx_th;
  logic [6:0]  rx_th;
  logic        tx_below;
  logic        tx_empty;

  always_comb begin
    state_next = state_reg;
    wr_acc     = psel && penable && pwrite;
    rd_acc     = psel && penable && !pwrite;
    wb         = pwdata[7:0];
    dlab       = state_reg.line_ctl[lcr_dlab_bit];
    state_next.pready  = psel && !penable;
    state_next.pslverr = 1'b0;
    state_next.data_wr = 1'b0;
    state_next.data_rd = 1'b0;

    // registers are written at the access edge; ready answers without a wait state
    if (wr_acc && state_reg.pready) begin
      case (paddr)
        rbr_thr_off: begin
          if (dlab) begin
            state_next.divisor_low = wb; // [RULE_14]
          end else begin
            state_next.data_wr    = 1'b1;
            state_next.data_wdata = wb;
          end
        end
        ier_off: begin
          if (dlab) begin
            state_next.divisor_high = wb; // [RULE_14]
          end
        end
        fifo_ctl_off: begin
          if (wb[fcr_en_bit]) begin // [RULE_19]
            state_next.fifo_ctl[3:0] = wb[3:0];
            state_next.fifo_ctl[7:6] = wb[7:6]; // [RULE_05]
            if (state_reg.enh_feat[efr_enh_bit]) begin // [RULE_03]
              state_next.fifo_ctl[5:4] = wb[5:4];
            end
            state_next.fifo_ctl[2:1] = 2'h0;
          end
        end
        line_ctl_off:  state_next.line_ctl  = wb;
        modem_ctl_off: state_next.modem_ctl = wb;
        feat_ctl_off:  state_next.feat_ctl  = wb; // [RULE_04]
        enh_feat_off:  state_next.enh_feat  = wb;
        rx_lvl_off:    state_next.rx_prog_lvl = wb[6:0]; // [RULE_22]
        tx_lvl_off:    state_next.tx_prog_lvl = wb[6:0]; // [RULE_22]
        default:       state_next.data_wr = 1'b0;
      endcase
    end

    // decode on the setup edge so data and error stand together with ready
    if (psel && !penable && pwrite) begin
      state_next.prdata  = 32'h0;
      state_next.pslverr = !(paddr inside {rbr_thr_off, ier_off, fifo_ctl_off, line_ctl_off,
                             modem_ctl_off, feat_ctl_off, enh_feat_off, rx_lvl_off, tx_lvl_off});
    end
    if (psel && !penable && !pwrite) begin
      state_next.prdata = 32'h0;
      case (paddr)
        rbr_thr_off: begin
          if (dlab) begin
            state_next.prdata[7:0] = state_reg.divisor_low; // [RULE_14]
          end else begin
            state_next.prdata[7:0] = data_rdata;
            state_next.data_rd     = 1'b1;
          end
        end
        ier_off: begin
          if (dlab) begin
            state_next.prdata[7:0] = state_reg.divisor_high; // [RULE_14]
          end
        end
        line_ctl_off:  state_next.prdata[7:0] = state_reg.line_ctl;
        modem_ctl_off: state_next.prdata[7:0] = state_reg.modem_ctl;
        feat_ctl_off:  state_next.prdata[7:0] = state_reg.feat_ctl;
        enh_feat_off:  state_next.prdata[7:0] = state_reg.enh_feat;
        rx_lvl_off:    state_next.prdata[6:0] = state_reg.rx_prog_lvl;
        tx_lvl_off:    state_next.prdata[6:0] = state_reg.tx_prog_lvl;
        status_off:    state_next.prdata[17:0] = {state_reg.trig, state_reg.tx_fill_seen,
                                                  state_reg.txd};
        fmt_off:       state_next.prdata[10:0] = state_reg.fmt;
        fifo_ctl_off:  state_next.pslverr = 1'b1;
        default:       state_next.pslverr = 1'b1;
      endcase
    end
    if (!(psel && !penable) && !(psel && penable && !state_reg.pready)) begin
      state_next.pready = 1'b0;
    end

    // thresholds from the one shared table
    tbl   = trig_table_t'(state_reg.feat_ctl[feature_control_tbl_lsb +: 2]); // [RULE_04]
    tx_th = tx_level(tbl, state_reg.fifo_ctl[fcr_tx_trig_lsb +: 2],
                     state_reg.tx_prog_lvl); // [RULE_01] [RULE_06] [RULE_07]
    rx_th = rx_level(tbl, state_reg.fifo_ctl[fcr_rx_trig_lsb +: 2],
                     state_reg.rx_prog_lvl); // [RULE_05] [RULE_06] [RULE_07]
    state_next.trig.tx_thresh = tx_th;
    state_next.trig.rx_thresh = rx_th;

    // tx event: below threshold after a fill above it, else on empty after a fill
    tx_below = levels.tx_count < tx_th;
    tx_empty = levels.tx_count == 7'h00;
    if (levels.tx_count > tx_th) begin
      state_next.tx_over_thresh = 1'b1;
    end
    if (levels.tx_count != 7'h00) begin
      state_next.tx_fill_seen = 1'b1;
    end
    state_next.trig.tx_ready_event = 1'b0;
    if (state_reg.tx_over_thresh && tx_below) begin // [RULE_02]
      state_next.trig.tx_ready_event = 1'b1;
      state_next.tx_over_thresh      = 1'b0;
      state_next.tx_fill_seen        = 1'b0;
    end else if (!state_reg.tx_over_thresh && state_reg.tx_fill_seen && tx_empty) begin
      state_next.trig.tx_ready_event = 1'b1; // [RULE_02]
      state_next.tx_fill_seen        = 1'b0;
    end
    state_next.trig.rx_data_ready_event = levels.rx_count >= rx_th; // [RULE_20]

    // character format
    wlen = state_reg.line_ctl[1:0];
    state_next.fmt.data_bits = 4'h5 + {2'h0, wlen}; // [RULE_08]
    if (!state_reg.line_ctl[lcr_stop_bit]) begin
      state_next.fmt.stop_halves = 2'h2; // [RULE_09]
    end else if (wlen == 2'h0) begin
      state_next.fmt.stop_halves = 2'h3; // [RULE_09]
    end else begin
      state_next.fmt.stop_halves = 2'h0; // four halves, coded as wrap [RULE_09]
    end
    state_next.fmt.par_en        = state_reg.line_ctl[lcr_par_en_bit]; // [RULE_10]
    state_next.fmt.par_even      = state_reg.line_ctl[lcr_par_ty_bit]; // [RULE_11]
    state_next.fmt.par_forced    = state_reg.line_ctl[lcr_force_bit]; // [RULE_12]
    state_next.fmt.par_force_val = !state_reg.line_ctl[lcr_par_ty_bit]; // [RULE_12]
    state_next.fmt.tx_break      = state_reg.line_ctl[lcr_break_bit];

    // break holds the line low
    state_next.txd = state_reg.line_ctl[lcr_break_bit] ? 1'b0 : tx_serial; // [RULE_13]

    // modem outputs, auto flow steals the selected pin
    if (state_reg.enh_feat[efr_autorts_bit] && state_reg.modem_ctl[mcr_flow_bit]) begin
      state_next.dtr_n = !auto_dtr_assert; // [RULE_17] [RULE_21]
    end else begin
      state_next.dtr_n = !state_reg.modem_ctl[mcr_dtr_bit]; // [RULE_15]
    end
    if (state_reg.enh_feat[efr_autorts_bit] && !state_reg.modem_ctl[mcr_flow_bit]) begin
      state_next.rts_n = !auto_rts_assert; // [RULE_18] [RULE_21]
    end else begin
      state_next.rts_n = !state_reg.modem_ctl[mcr_rts_bit]; // [RULE_16]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg              <= '0;
      state_reg.fifo_ctl     <= fifo_ctl_rst; // [RULE_07]
      state_reg.line_ctl     <= line_ctl_rst;
      state_reg.modem_ctl    <= modem_ctl_rst;
      state_reg.feat_ctl     <= feat_ctl_rst;
      state_reg.enh_feat     <= enh_feat_rst;
      state_reg.rx_prog_lvl  <= prog_lvl_rst;
      state_reg.tx_prog_lvl  <= prog_lvl_rst;
      state_reg.divisor_low  <= divisor_low_rst;
      state_reg.divisor_high <= divisor_high_rst;
      state_reg.fmt.data_bits   <= 4'h5;
      state_reg.fmt.stop_halves <= 2'h2;
      state_reg.fmt.par_force_val <= 1'b1;
      state_reg.trig.tx_thresh <= lvl_1;
      state_reg.trig.rx_thresh <= lvl_1;
      state_reg.txd          <= 1'b1;
      state_reg.dtr_n        <= 1'b1;
      state_reg.rts_n        <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready     = state_reg.pready;
  assign prdata     = state_reg.prdata;
  assign pslverr    = state_reg.pslverr;
  assign data_wr    = state_reg.data_wr;
  assign data_wdata = state_reg.data_wdata;
  assign data_rd    = state_reg.data_rd;
  assign fmt        = state_reg.fmt;
  assign trig       = state_reg.trig;
  assign divisor    = {state_reg.divisor_high, state_reg.divisor_low};
  assign txd        = state_reg.txd;
  assign dtr_n      = state_reg.dtr_n;
  assign rts_n      = state_reg.rts_n;

endmodule : uart_line_format_fifo_trigger

//--- sim/uart_line_format_fifo_trigger_properties.sv
// checker: port-level properties of the line format and trigger block
`timescale 1ns/10ps
module line_format_checker
  import uart_line_format_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         srst,
  // register bus
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic         pready,
  input wire logic         data_wr,
  // levels, format and line
  input wire fifo_levels_t levels,
  input wire logic         tx_serial,
  input wire char_format_t fmt,
  input wire trig_events_t trig,
  input wire logic         txd
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after one wait state");
  ready_in_access_a: assert property (pready |-> psel && penable && !$past(pready))
    else $error("ready outside a single access cycle");
  data_write_cause_a: assert property (data_wr |->
    $past(psel && penable && pready && pwrite && paddr == 8'h00))
    else $error("data write pulse without a data register write");
  break_low_a: assert property (fmt.tx_break && $past(fmt.tx_break) |-> !txd)
    else $error("serial output high during break");
  serial_pass_a: assert property (!$past(srst) && !$past(srst, 2) && !fmt.tx_break &&
    !$past(fmt.tx_break) && !$past(fmt.tx_break, 2) |-> txd == $past(tx_serial))
    else $error("serial output does not follow the stream");
  stop_len_a: assert property ((fmt.stop_halves != 2'd1) &&
    (fmt.stop_halves != 2'd3 || fmt.data_bits == 4'd5) &&
    (fmt.stop_halves != 2'd0 || fmt.data_bits != 4'd5))
    else $error("stop length does not match word length");
  width_range_a: assert property (fmt.data_bits inside {[4'd5:4'd8]})
    else $error("word length out of range");
  forced_value_a: assert property (fmt.par_forced |-> fmt.par_force_val == !fmt.par_even)
    else $error("forced parity value wrong");
  rx_ready_level_a: assert property (!$past(srst) && !$past(srst, 2) &&
    $stable(levels.rx_count) && $stable(trig.rx_thresh) |->
    trig.rx_data_ready_event == (levels.rx_count >= trig.rx_thresh))
    else $error("receive ready level wrong");
  tx_event_cause_a: assert property (trig.tx_ready_event && $stable(trig.tx_thresh) |->
    $past(levels.tx_count) < trig.tx_thresh)
    else $error("transmit event while level not below threshold");

  cover property (trig.tx_ready_event);
  cover property (fmt.tx_break && !txd);
  cover property (data_wr);
endmodule : line_format_checker

bind uart_line_format_fifo_trigger line_format_checker i_chk (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .data_wr(data_wr), .levels(levels), .tx_serial(tx_serial), .fmt(fmt), .trig(trig),
  .txd(txd));

//--- sim/serial_far_end.sv
// far-end serial device: bit stream source, flow requests, break watch
`timescale 1ns/10ps
module serial_far_end (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // bench control and lines
  input  wire logic  hold_off,
  input  wire logic  txd,
  output logic       tx_serial,
  output logic       auto_rts_assert,
  output logic       auto_dtr_assert,
  output logic [7:0] low_run
);
  logic [7:0] lfsr;
  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr <= 8'h5a;
      low_run <= 8'h00;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      low_run <= txd ? 8'h00 : low_run + {7'h00, low_run != 8'hff};
    end
  end
  // stream bit is an lfsr tap stepped every cycle so a stale value cannot keep matching for long
  assign tx_serial = lfsr[0];
  assign auto_rts_assert = hold_off;
  assign auto_dtr_assert = hold_off;
endmodule : serial_far_end

//--- sim/uart_line_format_fifo_trigger_test.sv
// self-checking bench of the line format and fifo trigger block
`timescale 1ns/10ps
module uart_line_format_fifo_trigger_test
  import uart_line_format_pkg::*;
;
  logic         clk, srst, psel, penable, pwrite, pready, pslverr, err, hold_off;
  logic         data_wr, data_rd, tx_serial, auto_rts, auto_dtr, txd, dtr_n, rts_n;
  logic [7:0]   paddr, data_wdata, data_rdata, low_run, v;
  logic [31:0]  pwdata, prdata, rd;
  logic [15:0]  divisor;
  logic [1:0]   t, fr, ft;
  fifo_levels_t levels;
  char_format_t fmt;
  trig_events_t trig;
  int           num_errors, compares;
  localparam logic [6:0] rx_tab [12] = '{lvl_1, lvl_4, lvl_8, lvl_14, lvl_8, lvl_16,
    lvl_24, lvl_28, lvl_8, lvl_16, lvl_56, lvl_60};
  localparam logic [6:0] tx_tab [12] = '{lvl_1, lvl_1, lvl_1, lvl_1, lvl_16, lvl_8,
    lvl_24, lvl_30, lvl_8, lvl_16, lvl_32, lvl_56};

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  uart_line_format_fifo_trigger i_dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rd(data_rd), .data_rdata(data_rdata), .levels(levels), .tx_serial(tx_serial),
    .auto_rts_assert(auto_rts), .auto_dtr_assert(auto_dtr), .fmt(fmt), .trig(trig),
    .divisor(divisor), .txd(txd), .dtr_n(dtr_n), .rts_n(rts_n));
  serial_far_end i_far (.clk(clk), .srst(srst), .hold_off(hold_off), .txd(txd),
    .tx_serial(tx_serial), .auto_rts_assert(auto_rts), .auto_dtr_assert(auto_dtr),
    .low_run(low_run));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic char_format_t exp_fmt(input logic [7:0] l);
    char_format_t f;
    f.data_bits = 4'd5 + {2'b00, l[1:0]};
    f.stop_halves = !l[2] ? 2'd2 : (l[1:0] == 2'b00 ? 2'd3 : 2'd0);
    f.par_en = l[3];
    f.par_even = l[4];
    f.par_forced = l[5];
    f.par_force_val = !l[4];
    f.tx_break = l[6];
    return f;
  endfunction : exp_fmt

  function automatic logic [6:0] exp_thr(input logic [1:0] tb, input logic [1:0] f,
                                         input logic rx, input logic [6:0] p);
    if (tb == 2'd3) return p;
    return rx ? rx_tab[{tb, f}] : tx_tab[{tb, f}];
  endfunction : exp_thr

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // one transfer; holds the request until ready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle

  task automatic tx_step(input logic [6:0] c, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    levels.tx_count <= c;
    repeat (6) begin
      @(negedge clk);
      seen = seen | (trig.tx_ready_event === 1'b1);
    end
    chk(seen, exp, "transmit event");
  endtask : tx_step

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    data_rdata = 8'h00;
    levels = '0;
    hold_off = 1'b0;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'h91db));
    repeat (5) @(posedge clk);
    chk({dtr_n, rts_n, txd, divisor}, {3'b111, 16'h0001}, "pins after reset");
    srst <= 1'b0;
    settle();
    chk(fmt, exp_fmt(8'h00), "format after reset");
    chk({trig.tx_thresh, trig.rx_thresh}, {lvl_1, lvl_1}, "levels after reset");
    for (int i = 0; i < 20; i++) begin
      v = (i < 8) ? 8'(i * 9) : (8'($urandom) & 8'h7f);
      apb(1'b1, line_ctl_off, {24'h0, v});
      settle();
      chk(fmt, exp_fmt(v), "format");
      if (v[6]) chk({txd, low_run > 8'd0}, 2'b01, "break line");
      apb(1'b0, line_ctl_off, 32'h0);
      chk(rd, {24'h0, v}, "line control readback");
    end
    apb(1'b1, rx_lvl_off, 32'h25);
    apb(1'b1, tx_lvl_off, 32'h2a);
    apb(1'b1, enh_feat_off, 32'h10);
    for (int i = 0; i < 16; i++) begin
      t = 2'(i >> 2);
      fr = 2'(i);
      ft = ~fr;
      apb(1'b1, feat_ctl_off, {24'h0, t, 6'h0});
      apb(1'b1, fifo_ctl_off, {24'h0, fr, ft, 4'h1});
      settle();
      chk(trig.rx_thresh, exp_thr(t, fr, 1'b1, 7'h25), "rx level");
      chk(trig.tx_thresh, exp_thr(t, ft, 1'b0, 7'h2a), "tx level");
    end
    apb(1'b1, feat_ctl_off, 32'h40);
    apb(1'b1, fifo_ctl_off, 32'hf1);
    apb(1'b1, fifo_ctl_off, 32'h00);
    settle();
    chk({trig.rx_thresh, trig.tx_thresh}, {lvl_28, lvl_30}, "disabled write");
    apb(1'b1, enh_feat_off, 32'h00);
    apb(1'b1, fifo_ctl_off, 32'h01);
    settle();
    chk({trig.rx_thresh, trig.tx_thresh}, {lvl_8, lvl_30}, "tx field locked");
    for (int i = 0; i < 10; i++) begin
      v = (i < 2) ? 8'(7 + i) : (8'($urandom) & 8'h3f);
      @(posedge clk);
      levels.rx_count <= v[6:0];
      settle();
      chk(trig.rx_data_ready_event, v >= 8'd8, "rx ready");
    end
    tx_step(7'd20, 1'b0);
    tx_step(7'd10, 1'b0);
    tx_step(7'd0, 1'b1);
    tx_step(7'd40, 1'b0);
    tx_step(7'd29, 1'b1);
    apb(1'b1, line_ctl_off, 32'h80);
    apb(1'b1, rbr_thr_off, 32'h34);
    @(negedge clk);
    chk(data_wr, 1'b0, "no data write with divisor access");
    apb(1'b1, ier_off, 32'h12);
    settle();
    chk(divisor, 16'h1234, "divisor");
    apb(1'b1, line_ctl_off, 32'h03);
    v = 8'($urandom);
    apb(1'b1, rbr_thr_off, {24'h0, v});
    @(negedge clk);
    chk({data_wr, data_wdata}, {1'b1, v}, "data write");
    @(posedge clk);
    data_rdata <= ~v;
    apb(1'b0, rbr_thr_off, 32'h0);
    chk(rd, {24'h0, ~v}, "data read");
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1, "unmapped read");
    apb(1'b0, fifo_ctl_off, 32'h0);
    chk(err, 1'b1, "write-only read");
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? 8'(i) : (8'($urandom) & 8'h07);
      apb(1'b1, modem_ctl_off, {24'h0, v});
      settle();
      chk({dtr_n, rts_n}, {!v[0], !v[1]}, "general pins");
    end
    apb(1'b1, enh_feat_off, 32'h40);
    apb(1'b1, modem_ctl_off, 32'h00);
    @(posedge clk);
    hold_off <= 1'b1;
    settle();
    chk({dtr_n, rts_n}, 2'b10, "auto on request pair");
    apb(1'b1, modem_ctl_off, 32'h04);
    settle();
    chk({dtr_n, rts_n}, 2'b01, "auto on ready pair");
    apb(1'b0, modem_ctl_off, 32'h0);
    chk(rd, 32'h04, "modem control readback");
    test_done();
  end
endmodule : uart_line_format_fifo_trigger_test
